//--- hdl/wer_pkg.sv
package wer_pkg;

   // Register geometry
   localparam int ADDR_W = 8;
   localparam int IDX_W  = 6;
   localparam int DATA_W = 32;
   localparam int REG_W  = 8;
   localparam int IDX_LSB = 2;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_IRQ_LOW       = 6'h02;
   localparam logic [IDX_W-1:0] IDX_IRQ_HIGH      = 6'h03;
   localparam logic [IDX_W-1:0] IDX_SMI_LOW       = 6'h04;
   localparam logic [IDX_W-1:0] IDX_BANK_SEL      = 6'h07;
   localparam logic [IDX_W-1:0] IDX_PEND_IRQ_LOW  = 6'h08;
   localparam logic [IDX_W-1:0] IDX_PEND_IRQ_HIGH = 6'h09;
   localparam logic [IDX_W-1:0] IDX_PEND_SMI_LOW  = 6'h0a;
   localparam logic [IDX_W-1:0] IDX_ROUTE_STAT    = 6'h0b;

   // Reset values and write masks
   localparam logic [REG_W-1:0]  ENABLE_RST     = 8'h00;
   localparam logic [REG_W-1:0]  BANK_SEL_RST   = 8'h00;
   localparam logic [REG_W-1:0]  IRQ_HIGH_WMASK = 8'hc2;
   localparam logic [REG_W-1:0]  REG_ZERO       = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO      = 32'h0000_0000;

   // Status word slices seen by this block
   localparam int STS_MSB      = 31;
   localparam int STS_LSB      = 16;
   localparam int STS_LOW_LSB  = 16;
   localparam int STS_HIGH_LSB = 24;

   // Route status bit positions
   localparam int ROUTE_IRQ_BIT = 0;
   localparam int ROUTE_SMI_BIT = 1;

   // Bus handshake states
   typedef enum logic {
      WER_IDLE = 1'b0,
      WER_ACK  = 1'b1
   } wer_fsm_type;

   // Low interrupt enable fields, bit 7 first
   typedef struct packed {
      logic power_button_irq_en;
      logic sleep_button_irq_en;
      logic key3_irq_en;
      logic key2_irq_en;
      logic anykey_irq_en;
      logic mouse_irq_en;
      logic ring_port2_irq_en;
      logic ring_port1_irq_en;
   } wer_irq_low_type;

   // High interrupt enable fields, bit 7 first
   typedef struct packed {
      logic       soft_poweroff_irq_en;
      logic       soft_poweron_irq_en;
      logic [3:0] rsvd_5_2;
      logic       kbc_port_pin_irq_en;
      logic       rsvd_0;
   } wer_irq_high_type;

   // Low management interrupt enable fields, bit 7 first
   typedef struct packed {
      logic power_button_smi_en;
      logic sleep_button_smi_en;
      logic key3_smi_en;
      logic key2_smi_en;
      logic anykey_smi_en;
      logic mouse_smi_en;
      logic ring_port2_smi_en;
      logic ring_port1_smi_en;
   } wer_smi_low_type;

endpackage

//--- hdl/wer_route.sv
`timescale 1ns/1ps
`default_nettype none
module wer_route
   import wer_pkg::*;
(
   input  wire logic [REG_W-1:0] status_in,
   input  wire logic [REG_W-1:0] enable_in,
   output logic      [REG_W-1:0] pending_out,
   output logic                  any_out
);

   genvar gi;
   generate
      for (gi = 0; gi < REG_W; gi++) begin : g_bit
         // A latched event passes only while its enable is one
         assign pending_out[gi] = status_in[gi] & enable_in[gi]; // [RULE6]
      end
   endgenerate

   assign any_out = |pending_out; // [RULE21]

endmodule // wer_route
`default_nettype wire

//--- hdl/wer_top.sv
// Functional notes
// RULE1: Low interrupt enable register gates status bits 16-23 onto the interrupt request.
// RULE2: High interrupt enable register gates status bits 24-31 onto the interrupt request.
// RULE3: Low management enable register gates status bits 16-23 onto the management interrupt.
// RULE4: All three enable registers reset to 00h, every route disabled.
// RULE5: Enables sit at indices 02h, 03h, 04h regardless of bank selection.
// RULE6: Enable value zero blocks a route and is default; one allows it.
// RULE7: Low interrupt enable bit 7 routes the power-button event.
// RULE8: Low interrupt enable bit 6 routes the sleep-button event.
// RULE9: Low interrupt enable bits 5 and 4 route key 3 and key 2.
// RULE10: Low interrupt enable bit 3 routes any-key, key sequence or key 1.
// RULE11: Low interrupt enable bit 2 routes the detected mouse event.
// RULE12: Low interrupt enable bits 1 and 0 route serial port 2 and 1 ring.
// RULE13: High interrupt enable bit 7 routes the software power-off event.
// RULE14: High interrupt enable bit 6 routes the software power-on event.
// RULE15: High interrupt enable bit 1 routes the keyboard-controller pin; bits 5-2, 0 reserved.
// RULE16: Management enable bits 7 and 6 route power and sleep buttons.
// RULE17: Management enable bits 5 and 4 route key 3 and key 2.
// RULE18: Management enable bit 3 routes any-key, key sequence or key 1.
// RULE19: Management enable bit 2 routes the detected mouse event.
// RULE20: Management enable bits 1 and 0 route serial port 2 and 1 ring.
// RULE21: Requests stay asserted while any latched status bit has its enable set.
// RULE22: Reserved enable bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module wer_top
   import wer_pkg::*;
(
   input  wire logic                  sys_clk_in,
   input  wire logic                  nrst_in,
   input  wire logic [ADDR_W-1:0]     avs_address_in,
   input  wire logic                  avs_read_in,
   input  wire logic                  avs_write_in,
   input  wire logic [DATA_W-1:0]     avs_writedata_in,
   input  wire logic [DATA_W/8-1:0]   avs_byteenable_in,
   output logic      [DATA_W-1:0]     avs_readdata_out,
   output logic                       avs_waitrequest_out,
   input  wire logic [STS_MSB:STS_LSB] wake_event_status_in,
   output logic                       irq_out,
   output logic                       smi_out
);

   typedef struct packed {
      wer_fsm_type      fsm;
      logic             waitrequest;
      logic [DATA_W-1:0] readdata;
      logic [IDX_W-1:0] cap_idx;
      logic             cap_write;
      logic             cap_be0;
      logic [REG_W-1:0] cap_data;
      wer_irq_low_type  irq_en_low;
      wer_irq_high_type irq_en_high;
      wer_smi_low_type  smi_en_low;
      logic [REG_W-1:0] bank_sel;
      logic             irq;
      logic             smi;
   } wer_state_type;

   localparam wer_state_type STATE_RST = '{
      fsm:         WER_IDLE,
      waitrequest: 1'b1,
      readdata:    READ_ZERO,
      cap_idx:     IDX_IRQ_LOW,
      cap_write:   1'b0,
      cap_be0:     1'b0,
      cap_data:    REG_ZERO,
      irq_en_low:  wer_irq_low_type'(ENABLE_RST),
      irq_en_high: wer_irq_high_type'(ENABLE_RST),
      smi_en_low:  wer_smi_low_type'(ENABLE_RST),
      bank_sel:    BANK_SEL_RST,
      irq:         1'b0,
      smi:         1'b0
   };

   wer_state_type r;
   wer_state_type r_nxt;

   logic [REG_W-1:0] sts_low;
   logic [REG_W-1:0] sts_high;
   logic [REG_W-1:0] irq_low_gate;
   logic [REG_W-1:0] irq_high_gate;
   logic [REG_W-1:0] smi_low_gate;
   logic [REG_W-1:0] pend_irq_low;
   logic [REG_W-1:0] pend_irq_high;
   logic [REG_W-1:0] pend_smi_low;
   logic             any_irq_low;
   logic             any_irq_high;
   logic             any_smi_low;
   logic [IDX_W-1:0] req_idx;
   logic [REG_W-1:0] rd_byte;
   logic [DATA_W-1:0] rd_word;

   // Enable bit positions; the low interrupt and low management registers share one layout
   localparam int POS_POWER_BTN = 7;
   localparam int POS_SLEEP_BTN = 6;
   localparam int POS_KEY3      = 5;
   localparam int POS_KEY2      = 4;
   localparam int POS_ANYKEY    = 3;
   localparam int POS_MOUSE     = 2;
   localparam int POS_RING2     = 1;
   localparam int POS_RING1     = 0;

   // High interrupt register positions; every other position is reserved
   localparam int POS_SOFT_OFF  = 7;
   localparam int POS_SOFT_ON   = 6;
   localparam int POS_KBC_PIN   = 1;

   // Only the lowest byte lane carries register data
   localparam int BE_LOW_LANE   = 0;

   assign sts_low  = wake_event_status_in[STS_LOW_LSB+REG_W-1:STS_LOW_LSB];   // [RULE1] [RULE3]
   assign sts_high = wake_event_status_in[STS_HIGH_LSB+REG_W-1:STS_HIGH_LSB]; // [RULE2]

   // Bank selection is never part of the decode
   assign req_idx = avs_address_in[ADDR_W-1:IDX_LSB]; // [RULE5]

   // Event-by-event gates, placed by field so each enable lands on its own status bit
   always_comb begin
      irq_low_gate = REG_ZERO;
      irq_low_gate[POS_POWER_BTN] = r.irq_en_low.power_button_irq_en; // [RULE7]
      irq_low_gate[POS_SLEEP_BTN] = r.irq_en_low.sleep_button_irq_en; // [RULE8]
      irq_low_gate[POS_KEY3]      = r.irq_en_low.key3_irq_en;         // [RULE9]
      irq_low_gate[POS_KEY2]      = r.irq_en_low.key2_irq_en;         // [RULE9]
      irq_low_gate[POS_ANYKEY]    = r.irq_en_low.anykey_irq_en;       // [RULE10]
      irq_low_gate[POS_MOUSE]     = r.irq_en_low.mouse_irq_en;        // [RULE11]
      irq_low_gate[POS_RING2]     = r.irq_en_low.ring_port2_irq_en;   // [RULE12]
      irq_low_gate[POS_RING1]     = r.irq_en_low.ring_port1_irq_en;   // [RULE12]
   end

   always_comb begin
      // Reserved positions stay closed even if a stray value got in
      irq_high_gate = REG_ZERO;
      irq_high_gate[POS_SOFT_OFF] = r.irq_en_high.soft_poweroff_irq_en; // [RULE13]
      irq_high_gate[POS_SOFT_ON]  = r.irq_en_high.soft_poweron_irq_en;  // [RULE14]
      irq_high_gate[POS_KBC_PIN]  = r.irq_en_high.kbc_port_pin_irq_en;  // [RULE15]
   end

   always_comb begin
      smi_low_gate = REG_ZERO;
      smi_low_gate[POS_POWER_BTN] = r.smi_en_low.power_button_smi_en; // [RULE16]
      smi_low_gate[POS_SLEEP_BTN] = r.smi_en_low.sleep_button_smi_en; // [RULE16]
      smi_low_gate[POS_KEY3]      = r.smi_en_low.key3_smi_en;         // [RULE17]
      smi_low_gate[POS_KEY2]      = r.smi_en_low.key2_smi_en;         // [RULE17]
      smi_low_gate[POS_ANYKEY]    = r.smi_en_low.anykey_smi_en;       // [RULE18]
      smi_low_gate[POS_MOUSE]     = r.smi_en_low.mouse_smi_en;        // [RULE19]
      smi_low_gate[POS_RING2]     = r.smi_en_low.ring_port2_smi_en;   // [RULE20]
      smi_low_gate[POS_RING1]     = r.smi_en_low.ring_port1_smi_en;   // [RULE20]
   end

   wer_route u_route_irq_low (
      .status_in   (sts_low),
      .enable_in   (irq_low_gate),
      .pending_out (pend_irq_low),
      .any_out     (any_irq_low)
   );

   wer_route u_route_irq_high (
      .status_in   (sts_high),
      .enable_in   (irq_high_gate),
      .pending_out (pend_irq_high),
      .any_out     (any_irq_high)
   );

   wer_route u_route_smi_low (
      .status_in   (sts_low),
      .enable_in   (smi_low_gate),
      .pending_out (pend_smi_low),
      .any_out     (any_smi_low)
   );

   // Read multiplexer; narrow registers sit in the low byte, unmapped reads give zero
   always_comb begin
      rd_byte = REG_ZERO;
      unique case (req_idx)
         IDX_IRQ_LOW: begin
            rd_byte = r.irq_en_low;
         end
         IDX_IRQ_HIGH: begin
            rd_byte = r.irq_en_high & IRQ_HIGH_WMASK; // [RULE22]
         end
         IDX_SMI_LOW: begin
            rd_byte = r.smi_en_low;
         end
         IDX_BANK_SEL: begin
            rd_byte = r.bank_sel;
         end
         IDX_PEND_IRQ_LOW: begin
            rd_byte = pend_irq_low;
         end
         IDX_PEND_IRQ_HIGH: begin
            rd_byte = pend_irq_high;
         end
         IDX_PEND_SMI_LOW: begin
            rd_byte = pend_smi_low;
         end
         IDX_ROUTE_STAT: begin
            rd_byte[ROUTE_IRQ_BIT] = r.irq;
            rd_byte[ROUTE_SMI_BIT] = r.smi;
         end
         default: begin
            // Unmapped words read zero so software can probe without side effects
            rd_byte = REG_ZERO;
         end
      endcase
   end

   assign rd_word = {{(DATA_W-REG_W){1'b0}}, rd_byte};

   always_comb begin
      r_nxt = r;

      // Level outputs follow the gated status one clock later
      r_nxt.irq = any_irq_low | any_irq_high; // [RULE21] [RULE1] [RULE2]
      r_nxt.smi = any_smi_low;                // [RULE21] [RULE3]

      unique case (r.fsm)
         WER_IDLE: begin
            r_nxt.waitrequest = 1'b1;
            if (avs_read_in || avs_write_in) begin
               // Capture lets the commit edge use exactly what was offered
               r_nxt.fsm         = WER_ACK;
               r_nxt.waitrequest = 1'b0;
               r_nxt.cap_idx     = req_idx;
               r_nxt.cap_write   = avs_write_in;
               r_nxt.cap_be0     = avs_byteenable_in[BE_LOW_LANE];
               r_nxt.cap_data    = avs_writedata_in[REG_W-1:0];
               // Read data is taken at the accepting edge and stands until the next request
               if (avs_read_in) begin
                  r_nxt.readdata = rd_word;
               end else begin
                  r_nxt.readdata = READ_ZERO;
               end
            end
         end

         WER_ACK: begin
            // Commit on the edge where the master sees waitrequest low
            r_nxt.fsm         = WER_IDLE;
            r_nxt.waitrequest = 1'b1;
            if (r.cap_write && r.cap_be0) begin
               unique case (r.cap_idx)
                  IDX_IRQ_LOW: begin
                     r_nxt.irq_en_low = wer_irq_low_type'(r.cap_data); // [RULE1] [RULE5]
                  end
                  IDX_IRQ_HIGH: begin
                     // Reserved positions never take a one, so they always read back zero
                     r_nxt.irq_en_high = wer_irq_high_type'(r.cap_data & IRQ_HIGH_WMASK); // [RULE2] [RULE22]
                  end
                  IDX_SMI_LOW: begin
                     r_nxt.smi_en_low = wer_smi_low_type'(r.cap_data); // [RULE3] [RULE5]
                  end
                  IDX_BANK_SEL: begin
                     // Kept for software only; the decode above never looks at it
                     r_nxt.bank_sel = r.cap_data;
                  end
                  default: begin
                     // Read-only and unmapped words drop the write
                     r_nxt.bank_sel = r.bank_sel;
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         r <= STATE_RST; // [RULE4]
      end else begin
         r <= r_nxt;
      end
   end

   assign avs_readdata_out    = r.readdata;
   assign avs_waitrequest_out = r.waitrequest;
   assign irq_out             = r.irq;
   assign smi_out             = r.smi;

endmodule // wer_top
`default_nettype wire

//--- testbench/wer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module wer_chk
   import wer_pkg::*;
(
   input wire logic                   sys_clk_in,
   input wire logic                   nrst_in,
   input wire logic [ADDR_W-1:0]      avs_address_in,
   input wire logic                   avs_read_in,
   input wire logic                   avs_write_in,
   input wire logic [DATA_W-1:0]      avs_writedata_in,
   input wire logic [DATA_W/8-1:0]    avs_byteenable_in,
   input wire logic [DATA_W-1:0]      avs_readdata_out,
   input wire logic                   avs_waitrequest_out,
   input wire logic [STS_MSB:STS_LSB] wake_event_status_in,
   input wire logic                   irq_out,
   input wire logic                   smi_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   logic [REG_W-1:0] lo_r;
   logic [REG_W-1:0] hi_r;
   logic [REG_W-1:0] sm_r;
   logic             irq_exp;
   logic             smi_exp;
   wire              wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
   // Shadow enables; a write lands only at the edge that sees waitrequest low
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         lo_r <= ENABLE_RST;
         hi_r <= ENABLE_RST;
         sm_r <= ENABLE_RST;
      end else if (wr_ok) begin
         if (avs_address_in[7:2] == IDX_IRQ_LOW) lo_r <= avs_writedata_in[7:0];
         if (avs_address_in[7:2] == IDX_IRQ_HIGH) hi_r <= avs_writedata_in[7:0] & IRQ_HIGH_WMASK;
         if (avs_address_in[7:2] == IDX_SMI_LOW) sm_r <= avs_writedata_in[7:0];
      end
   end
   assign irq_exp = |(wake_event_status_in[23:16] & lo_r) | |(wake_event_status_in[31:24] & hi_r);
   assign smi_exp = |(wake_event_status_in[23:16] & sm_r);
   sequence s_rd_taken(idx);
      avs_read_in && avs_waitrequest_out && avs_address_in[7:2] == idx;
   endsequence
   sequence s_ack;
      !avs_waitrequest_out;
   endsequence
   property p_irq_route;
      $past(nrst_in) |-> irq_out == $past(irq_exp);
   endproperty
   property p_smi_route;
      $past(nrst_in) |-> smi_out == $past(smi_exp);
   endproperty
   property p_reset_clear;
      disable iff (1'b0) !nrst_in |=> !irq_out && !smi_out && avs_waitrequest_out && avs_readdata_out == READ_ZERO;
   endproperty
   property p_read_low;
      s_rd_taken(IDX_IRQ_LOW) |=> s_ack and avs_readdata_out == DATA_W'($past(lo_r));
   endproperty
   property p_read_high;
      s_rd_taken(IDX_IRQ_HIGH) |=> s_ack and avs_readdata_out == DATA_W'($past(hi_r));
   endproperty
   property p_read_smi;
      s_rd_taken(IDX_SMI_LOW) |=> s_ack and avs_readdata_out == DATA_W'($past(sm_r));
   endproperty
   property p_answer;
      (avs_read_in || avs_write_in) |-> ##[0:2] s_ack;
   endproperty
   property p_idle_quiet;
      (lo_r == ENABLE_RST && hi_r == ENABLE_RST && sm_r == ENABLE_RST) |=> !irq_out && !smi_out;
   endproperty
   a_irq_route: assert property (p_irq_route)
      else $error("irq output differs from enabled status");
   a_smi_route: assert property (p_smi_route)
      else $error("smi output differs from enabled status");
   a_reset_clear: assert property (p_reset_clear)
      else $error("outputs not cleared by reset");
   a_read_low: assert property (p_read_low)
      else $error("low irq enable readback wrong");
   a_read_high: assert property (p_read_high)
      else $error("high irq enable readback wrong");
   a_read_smi: assert property (p_read_smi)
      else $error("smi enable readback wrong");
   a_answer: assert property (p_answer)
      else $error("request not answered in time");
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("request raised with all enables clear");
endmodule // wer_chk
bind wer_top wer_chk u_chk (.sys_clk_in, .nrst_in, .avs_address_in, .avs_read_in, .avs_write_in,
   .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
   .wake_event_status_in, .irq_out, .smi_out);
`default_nettype wire

//--- testbench/test_wake_event_irq_smi_routing.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module test_wake_event_irq_smi_routing
   import wer_pkg::*;
;
   logic                   clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic [ADDR_W-1:0]      addr = '0;
   logic                   rd = 1'b0;
   logic                   wr = 1'b0;
   logic [DATA_W-1:0]      wdata = '0;
   logic [DATA_W/8-1:0]    ben = '0;
   logic [STS_MSB:STS_LSB] sts = '0;
   logic [DATA_W-1:0]      rdata;
   logic                   waitreq;
   logic                   irq;
   logic                   smi;
   logic [DATA_W-1:0]      q;
   logic [IDX_W-1:0]       idx [3] = '{IDX_IRQ_LOW, IDX_IRQ_HIGH, IDX_SMI_LOW};
   int                     err_count = 0;
   int                     n_checks = 0;

   wer_top uut (.sys_clk_in(clk), .nrst_in(rst_n), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(ben), .avs_readdata_out(rdata),
      .avs_waitrequest_out(waitreq), .wake_event_status_in(sts), .irq_out(irq), .smi_out(smi));

   initial begin
      forever #4 clk = ~clk;
   end

   // Request held until waitrequest is seen low or 50 clocks pass; no fixed latency is assumed
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [DATA_W/8-1:0] b, output logic [DATA_W-1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      rd <= !w;
      wr <= w;
      wdata <= d;
      ben <= b;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      if (n >= 50) err_count++;
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int r = 0; r < 3; r++) begin
         bus(1'b0, {idx[r], 2'b00}, '0, 4'h1, q);
         `CHK(q, DATA_W'(ENABLE_RST))
      end
      // One enable at a time: every other status bit set must not leak through
      for (int r = 0; r < 3; r++) begin
         for (int k = 0; k < 8; k++) begin
            bus(1'b1, {idx[r], 2'b00}, DATA_W'(8'h01 << k), 4'h1, q);
            sts <= ~(16'h0001 << (k + 8 * (r == 1)));
            repeat (2) @(posedge clk);
            #1;
            `CHK({irq, smi}, 2'b00)
            @(posedge clk);
            sts <= 16'h0001 << (k + 8 * (r == 1));
            repeat (2) @(posedge clk);
            #1;
            if (r == 0) `CHK(irq, 1'b1)
            if (r == 1) `CHK(irq, IRQ_HIGH_WMASK[k])
            if (r == 2) `CHK(smi, 1'b1)
            `CHK(r == 2 ? irq : smi, 1'b0)
         end
         bus(1'b1, {idx[r], 2'b00}, '0, 4'h1, q);
      end
      bus(1'b1, {IDX_IRQ_HIGH, 2'b00}, 32'hffff_ffff, 4'hf, q);
      bus(1'b0, {IDX_IRQ_HIGH, 2'b00}, '0, 4'h1, q);
      `CHK(q, DATA_W'(IRQ_HIGH_WMASK))
      bus(1'b1, {IDX_IRQ_LOW, 2'b00}, 32'h0000_00a5, 4'h1, q);
      bus(1'b1, {IDX_IRQ_LOW, 2'b00}, 32'h0000_005a, 4'h0, q);
      bus(1'b1, {IDX_SMI_LOW, 2'b00}, 32'h0000_003c, 4'h1, q);
      bus(1'b1, {IDX_BANK_SEL, 2'b00}, 32'h0000_0001, 4'h1, q);
      bus(1'b0, {IDX_IRQ_LOW, 2'b00}, '0, 4'h1, q);
      `CHK(q, 32'h0000_00a5)
      bus(1'b0, {IDX_SMI_LOW, 2'b00}, '0, 4'h1, q);
      `CHK(q, 32'h0000_003c)
      bus(1'b0, 8'hfc, '0, 4'h1, q);
      `CHK(q, READ_ZERO)
      @(posedge clk);
      sts <= 16'hffff;
      repeat (2) @(posedge clk);
      #1;
      `CHK({irq, smi}, 2'b11)
      // Pending views, route status and bank select follow what was written
      bus(1'b0, {IDX_PEND_IRQ_LOW, 2'b00}, '0, 4'h1, q);
      `CHK(q, 32'h0000_00a5)
      bus(1'b0, {IDX_PEND_IRQ_HIGH, 2'b00}, '0, 4'h1, q);
      `CHK(q, DATA_W'(IRQ_HIGH_WMASK))
      bus(1'b0, {IDX_PEND_SMI_LOW, 2'b00}, '0, 4'h1, q);
      `CHK(q, 32'h0000_003c)
      bus(1'b0, {IDX_ROUTE_STAT, 2'b00}, '0, 4'h1, q);
      `CHK(q, 32'h0000_0003)
      bus(1'b0, {IDX_BANK_SEL, 2'b00}, '0, 4'h1, q);
      `CHK(q, 32'h0000_0001)
      // A one-cycle reset in mid-run must still wipe every route
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      for (int r = 0; r < 3; r++) begin
         bus(1'b0, {idx[r], 2'b00}, '0, 4'h1, q);
         `CHK(q, DATA_W'(ENABLE_RST))
      end
      #1;
      `CHK({irq, smi}, 2'b00)
      tally_and_finish;
   end

   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      tally_and_finish;
   end
endmodule // test_wake_event_irq_smi_routing
`default_nettype wire
